// ### src/rxd_deserializer.sv
// Serial-to-parallel receive front end with a byte FIFO and APB registers.
// Assumes rxLine is asynchronous to sys_clk and idles high between frames.
//
// Contract
// - A frame is start, eight data, stop; only data bits are kept.
// - A new frame is found by a falling edge on the line.
// - Each falling edge gives an edge pulse of exactly one cycle.
// - The edge pulse sets the start latch, which holds high.
// - Latch start plus 924 us raises frame end.
// - Shift ticks are spaced one 104 us bit period apart.
// - Shift ticks occur only during a frame, never while idle.
// - Bits enter LSB first, byte presented on bits [7:0].
// - Frame end clears the bit counter; the start latch clears after the latch delay.
// - Latch clears three 2 MHz cycles after frame end.
// - Select is low while shifting and high after the frame.
// - First shift tick comes half a bit after the latch sets.
// - Bit counter runs only after the half-bit delay is over.
// - After the frame the byte is presented on parallel outputs.

`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------
module rxd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("rxd_fifo: DEPTH must be a power of two >= 2");
  end

  assign outValid = (wrPtr_q != rdPtr_q);
  assign inReady  = (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0])
                    || (wrPtr_q[AW] == rdPtr_q[AW]);
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (inValid && inReady) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// Receive front end
// ------------------------------------------------------------------
module rxd_deserializer #(
  parameter int HALF_CYC  = rxd_pkg::HALF_BIT_CYC,
  parameter int BIT_CYC   = rxd_pkg::BIT_CYC,
  parameter int END_CYC   = rxd_pkg::FRAME_END_CYC,
  parameter int FIFO_DPTH = rxd_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        rxLine,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       parOut,
  output logic             shiftSelN
);
  import rxd_pkg::*;

  localparam int CW = 20;

  initial begin
    if (HALF_CYC < 1 || BIT_CYC <= HALF_CYC || END_CYC >= (1 << CW)
        || END_CYC <= HALF_CYC + (DATA_BITS * BIT_CYC))
      $error("rxd_deserializer: timing counts out of range");
  end

  rxd_state_t      state_q;
  logic            rxMeta_q, rxSync_q, rxPrev_q;
  logic            edgePulse_q;
  logic [CW-1:0]   frameCnt_q;
  logic [CW-1:0]   bitCnt_q;
  logic [7:0]      pipeCnt_q;
  logic [7:0]      shift_q;
  logic [3:0]      tickNum_q;
  logic            rxEnable_q;
  logic            overrun_q;
  logic            pready_q;
  logic            shiftTick;
  logic            frameDone;
  logic            fifoInReady, fifoOutValid;
  logic [7:0]      fifoOutData;
  logic            apbSetup, apbDone, popFifo, ovrClear;

  // ----------------------------------------------------------------
  // Line synchroniser and edge pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= rxLine;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edgePulse_q <= 1'b0;
    end else begin
      edgePulse_q <= rxPrev_q && !rxSync_q;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer; any state but idle is the start latch
  // ----------------------------------------------------------------
  // half-bit then bit ticks
  assign shiftTick = ((state_q == ST_HALF)
                      && (frameCnt_q == CW'(HALF_CYC - 1)))
                  || ((state_q == ST_SHIFT)
                      && (bitCnt_q == CW'(BIT_CYC - 1)));
  assign frameDone = (state_q == ST_END)
                     && (pipeCnt_q == 8'(LATCH_DLY_CYC - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (edgePulse_q && rxEnable_q) begin
            state_q <= ST_HALF;
          end
        end
        ST_HALF: begin
          if (shiftTick) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (frameCnt_q == CW'(END_CYC - 1)) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          if (frameDone) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frameCnt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      frameCnt_q <= '0;
    end else begin
      frameCnt_q <= frameCnt_q + 1'b1;
    end
  end

  // bit counter, cleared on each tick and outside the shift state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q <= '0;
    end else if (state_q != ST_SHIFT || shiftTick) begin
      bitCnt_q <= '0;
    end else begin
      bitCnt_q <= bitCnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pipeCnt_q <= '0;
    end else if (state_q != ST_END) begin
      pipeCnt_q <= '0;
    end else begin
      pipeCnt_q <= pipeCnt_q + 1'b1;
    end
  end

  // LSB-first shift; start bit falls out after nine ticks
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q   <= '0;
      tickNum_q <= '0;
    end else begin
      if (shiftTick) begin
        shift_q   <= {rxSync_q, shift_q[7:1]};
        tickNum_q <= tickNum_q + 1'b1;
      end else if (state_q == ST_IDLE) begin
        tickNum_q <= '0;
      end
    end
  end

  // select low only from latch set until frame end, half-bit delay included
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftSelN <= 1'b1;
    end else begin
      shiftSelN <= !((state_q == ST_IDLE && edgePulse_q && rxEnable_q)
                  || state_q == ST_HALF
                  || (state_q == ST_SHIFT && frameCnt_q != CW'(END_CYC - 1)));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      parOut <= '0;
    end else if (frameDone) begin
      parOut <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Byte FIFO; a full FIFO drops the byte and flags overrun
  // ----------------------------------------------------------------
  rxd_fifo #(
    .WIDTH (DATA_BITS),
    .DEPTH (FIFO_DPTH)
  ) uFifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inData   (shift_q),
    .inValid  (frameDone),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (popFifo)
  );

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  assign apbSetup = psel && penable && !pready_q;
  assign apbDone  = psel && penable && pready_q;
  assign popFifo  = apbDone && !pwrite && paddr == DATA_OFS;
  assign ovrClear = apbDone && pwrite && paddr == STATUS_OFS
                    && pwdata[STAT_OVR_BIT];
  assign pready   = pready_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready_q <= apbSetup;
      if (apbSetup) begin
        pslverr <= 1'b0;
        prdata  <= '0;
        unique case (paddr)
          CTRL_OFS:   prdata[CTRL_EN_BIT] <= rxEnable_q;
          STATUS_OFS: prdata[3:0] <= {overrun_q, !fifoInReady,
                                      fifoOutValid, state_q != ST_IDLE};
          DATA_OFS:   prdata[7:0] <= fifoOutValid ? fifoOutData : 8'h00;
          LAST_OFS:   prdata[7:0] <= parOut;
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxEnable_q <= CTRL_EN_RST;
    end else if (apbDone && pwrite && paddr == CTRL_OFS) begin
      rxEnable_q <= pwdata[CTRL_EN_BIT];
    end
  end

  // A drop in the same cycle as a clear still sets the flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_q <= 1'b0;
    end else if (frameDone && !fifoInReady) begin
      overrun_q <= 1'b1;
    end else if (ovrClear) begin
      overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  int halfI;
  int bitI;
  int endI;
  assign halfI = HALF_CYC;
  assign bitI  = BIT_CYC;
  assign endI  = END_CYC;

  a_pulse_width: assert property (
    edgePulse_q |=> !edgePulse_q)
    else $error("edge pulse longer than one cycle");

  a_edge_cause: assert property (
    edgePulse_q |-> $past(rxPrev_q) && !$past(rxSync_q))
    else $error("edge pulse without falling edge");

  a_latch_set: assert property (
    state_q == ST_IDLE && edgePulse_q && rxEnable_q |=> state_q == ST_HALF)
    else $error("start latch not set by edge pulse");

  a_idle_quiet: assert property (
    state_q == ST_IDLE |-> !shiftTick && bitCnt_q == '0)
    else $error("shift tick while idle");

  a_tick_place: assert property (
    shiftTick |-> int'(frameCnt_q) == halfI - 1 + int'(tickNum_q) * bitI)
    else $error("shift tick off the bit centre");

  a_frame_end: assert property (
    $rose(state_q == ST_END) |-> int'($past(frameCnt_q)) == endI - 1)
    else $error("frame end not at its delay");

  a_latch_clear: assert property (
    $fell(state_q != ST_IDLE) |->
      int'($past(frameCnt_q)) == endI + LATCH_DLY_CYC - 1
      && bitCnt_q == '0)
    else $error("latch clear timing wrong");

  a_nine_ticks: assert property (
    frameDone |-> tickNum_q == 4'(DATA_BITS + 1))
    else $error("wrong number of samples in frame");

  a_select_low: assert property (
    state_q == ST_END |=> shiftSelN)
    else $error("select still low after frame");

  a_par_out: assert property (
    frameDone |=> parOut == $past(shift_q))
    else $error("parallel byte not presented");

  a_rearm: assert property (
    frameDone |=> state_q == ST_IDLE ##1 state_q == ST_IDLE)
    else $error("not idle after frame");

endmodule

`default_nettype wire

// ### src/rxd_pkg.sv
// Constants shared by the serial receive front end.
// Assumes a 100 MHz system clock and a 9600 bps idle-high line.
package rxd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int BIT_NS      = 104000;
  localparam int HALF_BIT_NS = 52000;
  localparam int FRAME_END_NS = 924000;
  // Three cycles of the 2 MHz oscillator
  localparam int LATCH_DLY_NS = 1500;
  localparam int BIT_CYC      = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_END_CYC = (FRAME_END_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATCH_DLY_CYC = (LATCH_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_BITS   = 10;
  localparam int DATA_BITS    = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] LAST_OFS   = 8'h0C;
  localparam int CTRL_EN_BIT    = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam int STAT_FULL_BIT  = 2;
  localparam int STAT_OVR_BIT   = 3;
  localparam logic CTRL_EN_RST  = 1'b1;
  localparam int FIFO_DEPTH     = 16;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_HALF  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_END   = 4'h8
  } rxd_state_t;

endpackage

// ### tb/rxd_deserializer_bench.sv
// Self-checking bench for the serial receive front end.
// Assumes shortened bit timing and the fixed 150-cycle latch delay.
`timescale 1ns/10ps
`default_nettype none
module rxd_deserializer_bench;
  import rxd_pkg::*;
  localparam int HALF = 5;
  localparam int BITC = 10;
  localparam int ENDC = 92;
  logic        sys_clk;
  logic        rst_b;
  logic        rxLine;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        shiftSelN;
  logic [7:0]  paddr;
  logic [7:0]  parOut;
  logic [7:0]  lastByte;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  int          nErrors = 0;
  int          nChecks = 0;
  int          cycles = 0;

  rxd_line_driver #(.BIT_CYC(BITC)) drv (.sys_clk(sys_clk), .txLine(rxLine));
  rxd_deserializer #(.HALF_CYC(HALF), .BIT_CYC(BITC), .END_CYC(ENDC),
    .FIFO_DPTH(16)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .rxLine(rxLine),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .parOut(parOut), .shiftSelN(shiftSelN));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (nErrors == 0 && nChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run is far below this; a hang ends here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string msg);
    nChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %0t %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic errExp);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    if (!w) check(prdata, exp, "read data");
    check(pslverr, errExp, "slave error");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sends one byte, times select and parallel output
  task automatic frame(input logic [7:0] b);
    int n;
    fork
      drv.sendByte(b);
      begin
        n = 0;
        while (shiftSelN !== 1'b0 && n < 20) begin
          @(posedge sys_clk);
          n++;
        end
        check(n < 20, 1, "start not seen");
        n = 0;
        while (shiftSelN === 1'b0 && n < 200) begin
          @(posedge sys_clk);
          n++;
        end
        check(n, ENDC, "select low width");
        repeat (140) @(posedge sys_clk);
        check(parOut, lastByte, "byte too early");
        repeat (20) @(posedge sys_clk);
        check(parOut, b, "parallel byte");
        check(shiftSelN, 1'b1, "not idle");
      end
    join
    lastByte = b;
    apb(LAST_OFS, 1'b0, 0, {24'h0, b}, 1'b0);
  endtask

  task automatic testIdle();
    check(parOut, 8'h00, "reset byte");
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      check(shiftSelN, 1'b1, "select while idle");
    end
    apb(CTRL_OFS, 1'b0, 0, 32'h1, 1'b0);
    apb(STATUS_OFS, 1'b0, 0, 32'h0, 1'b0);
    apb(DATA_OFS, 1'b0, 0, 32'h0, 1'b0);
    apb(8'h10, 1'b1, 32'hFF, 0, 1'b1);
    apb(8'h10, 1'b0, 0, 32'h0, 1'b1);
  endtask

  // Every data bit position both ways, then FIFO order
  task automatic testBytes();
    logic [7:0] tbl [6] = '{8'hA5, 8'h5A, 8'h01, 8'h80, 8'hFF, 8'h00};
    foreach (tbl[i]) frame(tbl[i]);
    foreach (tbl[i]) apb(DATA_OFS, 1'b0, 0, {24'h0, tbl[i]}, 1'b0);
    apb(STATUS_OFS, 1'b0, 0, 32'h0, 1'b0);
  endtask

  // With reception off the line is ignored
  task automatic testDisable();
    apb(CTRL_OFS, 1'b1, 32'h0, 0, 1'b0);
    drv.sendByte(8'h3C);
    for (int i = 0; i < 250; i++) begin
      @(posedge sys_clk);
      check(shiftSelN, 1'b1, "select while off");
    end
    check(parOut, lastByte, "byte while off");
    apb(CTRL_OFS, 1'b1, 32'h1, 0, 1'b0);
  endtask

  // Fill, overflow while full, drain, clear
  task automatic testFill();
    for (int i = 0; i < 16; i++) frame(8'hC0 + i[7:0]);
    apb(STATUS_OFS, 1'b0, 0, 32'h6, 1'b0);
    frame(8'h7E);
    apb(STATUS_OFS, 1'b0, 0, 32'hE, 1'b0);
    for (int i = 0; i < 16; i++)
      apb(DATA_OFS, 1'b0, 0, {24'h0, 8'hC0 + i[7:0]}, 1'b0);
    apb(STATUS_OFS, 1'b0, 0, 32'h8, 1'b0);
    apb(STATUS_OFS, 1'b1, 32'h8, 0, 1'b0);
    apb(STATUS_OFS, 1'b0, 0, 32'h0, 1'b0);
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lastByte = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    testIdle();
    testBytes();
    testDisable();
    testFill();
    results();
  end
endmodule
`default_nettype wire

// ### tb/rxd_line_driver.sv
// Serial line partner: a sender of idle-high asynchronous frames.
// Assumes the bench calls sendByte from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module rxd_line_driver #(
  parameter int BIT_CYC = 10
) (
  input  wire logic sys_clk,
  output var logic  txLine
);
  initial txLine = 1'b1;

  task automatic sendByte(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      txLine <= frm[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire
